// ==== rtl/dcs_pkg.sv ====
// Constants and types for the debug control/status byte.
// Assumes every user sits on the single bus clock domain.
package dcs_pkg;

    localparam int          CSR_W     = 8;
    localparam int          BIT_EN    = 7;
    localparam int          BIT_ACT   = 6;
    localparam int          BIT_CIS   = 5;
    localparam int          BIT_RSV   = 4;
    localparam int          BIT_STEAL = 3;
    localparam int          BIT_CLOCK_SWITCH_BIT = 2;
    localparam int          BIT_UNSECURE_STATUS_BIT = 1;
    localparam int          BIT_ERASE = 0;
    localparam logic [7:0]  CSR_RST   = 8'h00;

    // Debug link command codes (values arbitrary)
    localparam logic [7:0]  CMD_READ_CSR  = 8'h2d;
    localparam logic [7:0]  CMD_WRITE_CSR = 8'h0d;
    localparam logic [7:0]  CMD_ERASE     = 8'h95;
    localparam logic [7:0]  CMD_ENTER_DBG = 8'h90;
    localparam logic [7:0]  CMD_EXIT_DBG  = 8'h08;
    localparam logic [7:0]  CMD_MEM_ACC   = 8'h30;

    // Free-cycle wait limit with handshaking, in bus cycles
    localparam int          STEAL_TIMEOUT = 512;
    // Host-side settle time after a clock switch, in old-clock cycles
    localparam int          CLOCK_SWITCH_BIT_SETTLE_CYC = 150;

    typedef enum logic [1:0] {
        DCS_ARB_IDLE = 2'b00,
        DCS_ARB_WAIT = 2'b01
    } dcs_arb_e;

endpackage

// ==== rtl/dcs_steal_arb.sv ====
// Bus access arbiter for debug memory accesses: steal or wait.
// Assumes req is only raised while busy is low.
`timescale 1ns/10ps
module dcs_steal_arb
    import dcs_pkg::*;
#(
    parameter int TIMEOUT_CYC = STEAL_TIMEOUT,
    parameter int CNT_W       = $clog2(TIMEOUT_CYC)
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic req,
    input  wire logic ack_enable,
    input  wire logic steal,
    input  wire logic bus_free,
    output logic      busy,
    output logic      go,
    output logic      timeout
);

    dcs_arb_e         state_r;
    dcs_arb_e         state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             go_r;
    logic             go_nxt;
    logic             to_r;
    logic             to_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        go_nxt    = 1'b0;
        to_nxt    = 1'b0;
        case (state_r)
            DCS_ARB_IDLE: begin
                if (req) begin
                    if (!ack_enable || steal || bus_free) begin
                        go_nxt = 1'b1;
                    end else begin
                        state_nxt = DCS_ARB_WAIT;
                        cnt_nxt   = '0;
                    end
                end
            end
            DCS_ARB_WAIT: begin
                if (bus_free) begin
                    go_nxt    = 1'b1;
                    state_nxt = DCS_ARB_IDLE;
                end else if (cnt_r == CNT_W'(TIMEOUT_CYC - 1)) begin
                    to_nxt    = 1'b1;
                    state_nxt = DCS_ARB_IDLE;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            default: state_nxt = DCS_ARB_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= DCS_ARB_IDLE;
            cnt_r   <= '0;
            go_r    <= 1'b0;
            to_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            go_r    <= go_nxt;
            to_r    <= to_nxt;
        end
    end

    assign busy    = (state_r != DCS_ARB_IDLE) || go_r;
    assign go      = go_r;
    assign timeout = to_r;

    AST_STEAL_NEXT: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == DCS_ARB_IDLE && req && (!ack_enable || steal)) |=> go)
        else $error("steal access did not take next cycle");

    AST_WAIT_LIMIT: assert property (@(posedge clk) disable iff (!rst_n)
        timeout |-> ($past(cnt_r) == CNT_W'(TIMEOUT_CYC - 1)) && !$past(bus_free))
        else $error("timeout not after full wait");

endmodule

// ==== rtl/dcs_stop_ack.sv ====
// Stop-mode clock keep requests and long acknowledge flag.
// Assumes stop_mode and ack_issued are on the bus clock.
`timescale 1ns/10ps
module dcs_stop_ack (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic enable,
    input  wire logic stop_mode,
    input  wire logic stop_continue,
    input  wire logic ack_enable,
    input  wire logic ack_issued,
    output logic      keep_dbg_clk,
    output logic      keep_all_clk,
    output logic      ack_long
);

    logic stop_q_r;
    logic long_r;
    logic long_nxt;
    logic dbg_r;
    logic dbg_nxt;
    logic all_r;
    logic all_nxt;
    logic stop_entry;

    assign stop_entry = stop_mode && !stop_q_r;

    always_comb begin
        long_nxt = long_r;
        if (ack_issued) begin
            long_nxt = 1'b0;
        end
        // Entry wins over a clearing acknowledge in the same cycle
        if (stop_entry && ack_enable && enable) begin
            long_nxt = 1'b1;
        end
        dbg_nxt = stop_mode && enable;
        all_nxt = stop_mode && enable && stop_continue;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_q_r <= 1'b0;
            long_r   <= 1'b0;
            dbg_r    <= 1'b0;
            all_r    <= 1'b0;
        end else begin
            stop_q_r <= stop_mode;
            long_r   <= long_nxt;
            dbg_r    <= dbg_nxt;
            all_r    <= all_nxt;
        end
    end

    assign keep_dbg_clk = dbg_r;
    assign keep_all_clk = all_r;
    assign ack_long     = long_r;

    AST_LONG_ACK: assert property (@(posedge clk) disable iff (!rst_n)
        (stop_entry && ack_enable && enable) |=> ack_long)
        else $error("no long ack after stop entry");

    AST_NO_STOP_EFFECT: assert property (@(posedge clk) disable iff (!rst_n)
        !enable |=> !keep_dbg_clk && !keep_all_clk)
        else $error("disabled controller touched stop clocks");

endmodule

// ==== rtl/dcs_ctrl_top.sv ====
// Upper control/status byte of the serial debug controller.
// Reached only by commands from the debug link; all inputs on clk.
// Operation
// - Byte readable only by debug link commands
// - Link writes only while part unsecured
// - Enable, steal, clock-switch only via write command
// - Stop-continue write ignored during stop mode
// - Active, unsecure, erase bits never written
// - Enable gates active debug and command set
// - Special single-chip reset sets enable bit
// - Active set on entry, cleared on exit
// - Special single-chip reset sets active bit
// - Stop-continue picks clocks kept in stop
// - Disabled: no stop effect, no link traffic in stop mode
// - Long acknowledge after stop entry
// - Handshake, no steal: wait free, 512 limit
// - No handshake: always take next cycle
// - Clock switch sticky until any reset
// - Clock switch selects serial interface clock
// - Unsecure bit mirrors unsecured state
// - Erase set only by erase command
// - Erase cleared on completion or soft reset
`timescale 1ns/10ps
module dcs_ctrl_top
    import dcs_pkg::*;
#(
    parameter int TIMEOUT_CYC = STEAL_TIMEOUT
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             soft_rst,
    input  wire logic             special_mode,
    input  wire logic             secured,
    input  wire logic             stop_mode,
    input  wire logic             cmd_valid,
    input  wire logic [7:0]       cmd_code,
    input  wire logic [CSR_W-1:0] cmd_wdata,
    output logic                  cmd_accept,
    output logic                  cmd_refused,
    output logic                  rsp_valid,
    output logic [CSR_W-1:0]      rsp_data,
    input  wire logic             dbg_entry_req,
    input  wire logic             erase_done,
    output logic                  erase_start,
    input  wire logic             ack_enable,
    input  wire logic             ack_issued,
    output logic                  ack_long,
    input  wire logic             bus_free,
    output logic                  access_go,
    output logic                  access_timeout,
    output logic                  debug_enable,
    output logic                  debug_active,
    output logic                  keep_dbg_clk,
    output logic                  keep_all_clk,
    output logic                  si_clk_fast
);

    logic             init_r;
    logic             init_nxt;
    logic             en_r;
    logic             en_nxt;
    logic             act_r;
    logic             act_nxt;
    logic             cis_r;
    logic             cis_nxt;
    logic             steal_r;
    logic             steal_nxt;
    logic             clock_switch_bit_r;
    logic             clock_switch_bit_nxt;
    logic             erase_r;
    logic             erase_nxt;
    logic             rsp_valid_r;
    logic             rsp_valid_nxt;
    logic [CSR_W-1:0] rsp_data_r;
    logic [CSR_W-1:0] rsp_data_nxt;
    logic             erase_go_r;
    logic             erase_go_nxt;

    logic             link_ok;
    logic             restricted;
    logic             known;
    logic             arb_busy;
    logic             is_read;
    logic             is_write;
    logic             is_erase;
    logic             is_enter;
    logic             is_exit;
    logic             is_mem;
    logic             wr_ok;
    logic             enter_ok;
    logic [CSR_W-1:0] csr_view;

    // Command decode
    assign is_read  = cmd_code == CMD_READ_CSR;
    assign is_write = cmd_code == CMD_WRITE_CSR;
    assign is_erase = cmd_code == CMD_ERASE;
    assign is_enter = cmd_code == CMD_ENTER_DBG;
    assign is_exit  = cmd_code == CMD_EXIT_DBG;
    assign is_mem   = cmd_code == CMD_MEM_ACC;

    // Disabled controller keeps only the byte and erase commands
    assign restricted = is_read || is_write || is_erase;
    assign known      = restricted
                        || (is_enter && en_r)
                        || (is_exit && act_r)
                        || (is_mem && !arb_busy);
    // Stopped and disabled: the link stays silent
    assign link_ok    = init_r && (en_r || !stop_mode);

    always_comb begin
        cmd_accept = 1'b0;
        if (cmd_valid && link_ok) begin
            cmd_accept = en_r ? known : restricted;
        end
    end

    assign cmd_refused = cmd_valid && !cmd_accept;
    assign wr_ok       = cmd_accept && is_write && !secured;
    assign enter_ok    = en_r && ((cmd_accept && is_enter) || dbg_entry_req);

    // Readback view; unsecure bit is live, bit four is zero
    always_comb begin
        csr_view            = CSR_RST;
        csr_view[BIT_EN]    = en_r;
        csr_view[BIT_ACT]   = act_r;
        csr_view[BIT_CIS]   = cis_r;
        csr_view[BIT_RSV]   = 1'b0;
        csr_view[BIT_STEAL] = steal_r;
        csr_view[BIT_CLOCK_SWITCH_BIT] = clock_switch_bit_r;
        csr_view[BIT_UNSECURE_STATUS_BIT] = !secured;
        csr_view[BIT_ERASE] = erase_r;
    end

    // Control and status bits
    always_comb begin
        init_nxt  = 1'b1;
        en_nxt    = en_r;
        act_nxt   = act_r;
        cis_nxt   = cis_r;
        steal_nxt = steal_r;
        clock_switch_bit_nxt = clock_switch_bit_r;
        erase_nxt = erase_r;

        if (!init_r) begin
            // Strap is caught after reset release, not under reset
            en_nxt  = special_mode;
            act_nxt = special_mode;
        end else begin
            // Active, unsecure and erase bits have no write path
            if (wr_ok) begin
                en_nxt    = cmd_wdata[BIT_EN];
                steal_nxt = cmd_wdata[BIT_STEAL];
                if (cmd_wdata[BIT_CLOCK_SWITCH_BIT]) begin
                    clock_switch_bit_nxt = 1'b1;
                end
                if (!stop_mode) begin
                    cis_nxt = cmd_wdata[BIT_CIS];
                end
            end
            if (cmd_accept && is_exit) begin
                act_nxt = 1'b0;
            end
            if (enter_ok) begin
                act_nxt = 1'b1;
            end
            if (erase_done) begin
                erase_nxt = 1'b0;
            end
            // Erase request wins over a completion in the same cycle
            if (cmd_accept && is_erase) begin
                erase_nxt = 1'b1;
            end
        end

        // Soft reset acts as a full reset of the byte
        if (soft_rst) begin
            init_nxt  = 1'b0;
            en_nxt    = CSR_RST[BIT_EN];
            act_nxt   = CSR_RST[BIT_ACT];
            cis_nxt   = CSR_RST[BIT_CIS];
            steal_nxt = CSR_RST[BIT_STEAL];
            clock_switch_bit_nxt = CSR_RST[BIT_CLOCK_SWITCH_BIT];
            erase_nxt = CSR_RST[BIT_ERASE];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_r  <= 1'b0;
            en_r    <= CSR_RST[BIT_EN];
            act_r   <= CSR_RST[BIT_ACT];
            cis_r   <= CSR_RST[BIT_CIS];
            steal_r <= CSR_RST[BIT_STEAL];
            clock_switch_bit_r <= CSR_RST[BIT_CLOCK_SWITCH_BIT];
            erase_r <= CSR_RST[BIT_ERASE];
        end else begin
            init_r  <= init_nxt;
            en_r    <= en_nxt;
            act_r   <= act_nxt;
            cis_r   <= cis_nxt;
            steal_r <= steal_nxt;
            clock_switch_bit_r <= clock_switch_bit_nxt;
            erase_r <= erase_nxt;
        end
    end

    // Link answers and erase launch
    always_comb begin
        rsp_valid_nxt = 1'b0;
        rsp_data_nxt  = rsp_data_r;
        erase_go_nxt  = 1'b0;
        if (cmd_accept && is_read) begin
            rsp_valid_nxt = 1'b1;
            rsp_data_nxt  = csr_view;
        end
        if (cmd_accept && is_erase && !soft_rst) begin
            erase_go_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_r <= 1'b0;
            rsp_data_r  <= CSR_RST;
            erase_go_r  <= 1'b0;
        end else begin
            rsp_valid_r <= rsp_valid_nxt;
            rsp_data_r  <= rsp_data_nxt;
            erase_go_r  <= erase_go_nxt;
        end
    end

    dcs_steal_arb #(
        .TIMEOUT_CYC (TIMEOUT_CYC)
    ) u_arb (
        .clk        (clk),
        .rst_n      (rst_n),
        .req        (cmd_accept && is_mem),
        .ack_enable (ack_enable),
        .steal      (steal_r),
        .bus_free   (bus_free),
        .busy       (arb_busy),
        .go         (access_go),
        .timeout    (access_timeout)
    );

    dcs_stop_ack u_stop (
        .clk           (clk),
        .rst_n         (rst_n),
        .enable        (en_r),
        .stop_mode     (stop_mode),
        .stop_continue (cis_r),
        .ack_enable    (ack_enable),
        .ack_issued    (ack_issued),
        .keep_dbg_clk  (keep_dbg_clk),
        .keep_all_clk  (keep_all_clk),
        .ack_long      (ack_long)
    );

    assign rsp_valid    = rsp_valid_r;
    assign rsp_data     = rsp_data_r;
    assign erase_start  = erase_go_r;
    assign debug_enable = en_r;
    assign debug_active = act_r;
    // Host must hold off CLOCK_SWITCH_BIT_SETTLE_CYC old-clock cycles after a switch
    assign si_clk_fast  = clock_switch_bit_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_READ_ANSWER: assert property (
        (cmd_accept && is_read) |=> rsp_valid && (rsp_data == $past(csr_view)))
        else $error("read answer missing or wrong");

    AST_SECURED_WRITE: assert property (
        (init_r && !soft_rst && cmd_valid && is_write && secured)
        |=> $stable(en_r) && $stable(steal_r) && $stable(cis_r))
        else $error("write took effect while secured");

    AST_WRITE_PATH: assert property (
        (init_r && !soft_rst && !wr_ok) |=> $stable(en_r) && $stable(steal_r))
        else $error("control bit changed without write command");

    AST_STOP_CONTINUE: assert property (
        (stop_mode && !soft_rst) |=> $stable(cis_r))
        else $error("stop-continue changed in stop mode");

    AST_ERASE_CAUSE: assert property (
        $rose(erase_r) |-> $past(cmd_accept) && ($past(cmd_code) == CMD_ERASE))
        else $error("erase bit set without erase command");

    AST_ACTIVE_NEEDS_EN: assert property (
        (init_r && !act_r && !en_r && !soft_rst) |=> !act_r)
        else $error("active debug entered while disabled");

    AST_STRAP_LOAD: assert property (
        (!init_r && special_mode && !soft_rst) |=> en_r && act_r)
        else $error("special mode strap not loaded");

    AST_ACTIVE_EXIT: assert property (
        (cmd_accept && is_exit && !enter_ok && !soft_rst) |=> !act_r ##1 !act_r || $past(enter_ok))
        else $error("active bit not cleared on exit");

    AST_CLOCK_SWITCH_BIT_STICKY: assert property (
        (clock_switch_bit_r && !soft_rst) |=> clock_switch_bit_r [*2] or (clock_switch_bit_r ##1 $past(soft_rst)))
        else $error("clock switch cleared without reset");

    AST_UNSECURE_READ: assert property (
        (cmd_accept && is_read) |=> rsp_data[BIT_UNSECURE_STATUS_BIT] == !$past(secured))
        else $error("unsecure bit wrong");

    AST_ERASE_DONE: assert property (
        (init_r && erase_done && !(cmd_accept && is_erase)) |=> !erase_r)
        else $error("erase bit not cleared on completion");

    AST_RSV_ZERO: assert property (
        rsp_valid |-> !rsp_data[BIT_RSV])
        else $error("bit four read nonzero");

endmodule

// ==== verification/dcs_host_pod.sv ====
// Debug host pod model: presents one link command at a time.
// Assumes it shares the controller clock and is called just after a rising edge.
`timescale 1ns/10ps
module dcs_host_pod
    import dcs_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             cmd_accept,
    input  wire logic             cmd_refused,
    input  wire logic             rsp_valid,
    input  wire logic [CSR_W-1:0] rsp_data,
    output logic                  cmd_valid,
    output logic [7:0]            cmd_code,
    output logic [CSR_W-1:0]      cmd_wdata
);
    logic             last_ok;
    logic             last_rf;
    logic             last_rv;
    logic [CSR_W-1:0] last_rd;

    initial begin
        cmd_valid = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 8'h00;
        last_ok   = 1'b0;
        last_rf   = 1'b0;
        last_rv   = 1'b0;
        last_rd   = 8'h00;
    end

    // Holds the command over one edge, then one more edge for the answer
    task automatic send(input logic [7:0] code, input logic [CSR_W-1:0] wd);
        cmd_valid <= 1'b1;
        cmd_code  <= code;
        cmd_wdata <= wd;
        @(posedge clk);
        last_ok = cmd_accept;
        last_rf = cmd_refused;
        cmd_valid <= 1'b0;
        // Released lines flip so a stale command never looks current
        cmd_code  <= ~code;
        cmd_wdata <= ~wd;
        @(posedge clk);
        last_rv = rsp_valid;
        last_rd = rsp_data;
        if (code == CMD_WRITE_CSR && last_ok && wd[BIT_CLOCK_SWITCH_BIT]) begin
            repeat (CLOCK_SWITCH_BIT_SETTLE_CYC) @(posedge clk);
        end
    endtask
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the debug control/status byte.
// Assumes the host pod model drives the command link.
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
    $display("BAD %0t got %0h exp %0h", $time, (a), (e)); end end
module testbench;
    import dcs_pkg::*;
    localparam int TO = 8;
    logic clk, rst_n, soft_rst, special_mode, secured, stop_mode;
    logic cmd_valid, cmd_accept, cmd_refused, rsp_valid;
    logic [7:0] cmd_code, cmd_wdata, rsp_data;
    logic dbg_entry_req, erase_done, erase_start, ack_enable, ack_issued, ack_long;
    logic bus_free, access_go, access_timeout, debug_enable, debug_active;
    logic keep_dbg_clk, keep_all_clk, si_clk_fast;
    int   err_total;
    int   comparisons;

    dcs_ctrl_top #(.TIMEOUT_CYC(TO)) dcs_ctrl_top_inst (
        .clk(clk), .rst_n(rst_n), .soft_rst(soft_rst), .special_mode(special_mode),
        .secured(secured), .stop_mode(stop_mode), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_accept(cmd_accept),
        .cmd_refused(cmd_refused), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .dbg_entry_req(dbg_entry_req), .erase_done(erase_done),
        .erase_start(erase_start), .ack_enable(ack_enable), .ack_issued(ack_issued),
        .ack_long(ack_long), .bus_free(bus_free), .access_go(access_go),
        .access_timeout(access_timeout), .debug_enable(debug_enable),
        .debug_active(debug_active), .keep_dbg_clk(keep_dbg_clk),
        .keep_all_clk(keep_all_clk), .si_clk_fast(si_clk_fast));

    dcs_host_pod dcs_host_pod_inst (
        .clk(clk), .cmd_accept(cmd_accept), .cmd_refused(cmd_refused), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic finish_test();
        if (err_total == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic hreset(input logic sm);
        special_mode <= sm;
        rst_n        <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(2);
    endtask

    task automatic soft_clear();
        soft_rst <= 1'b1;
        cyc(1);
        soft_rst <= 1'b0;
        cyc(2);
    endtask

    task automatic wr(input logic [7:0] d);
        dcs_host_pod_inst.send(CMD_WRITE_CSR, d);
    endtask

    // One-cycle strobe: 0 ack sent, 1 debug entry, other erase done
    task automatic pulse(input int sel);
        case (sel)
            0: ack_issued <= 1'b1;
            1: dbg_entry_req <= 1'b1;
            default: erase_done <= 1'b1;
        endcase
        cyc(1);
        ack_issued    <= 1'b0;
        dbg_entry_req <= 1'b0;
        erase_done    <= 1'b0;
        cyc(2);
    endtask

    task automatic rd_chk(input logic [7:0] e);
        dcs_host_pod_inst.send(CMD_READ_CSR, 8'h00);
        `CHK(dcs_host_pod_inst.last_rv, 1'b1)
        `CHK(dcs_host_pod_inst.last_rd, e)
    endtask

    task automatic mem_chk(input logic eg, input int en);
        int n;
        n = 1;
        dcs_host_pod_inst.send(CMD_MEM_ACC, 8'h00);
        while (access_go !== 1'b1 && access_timeout !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20) begin
            err_total++;
            finish_test();
        end
        `CHK(access_go, eg)
        if (en > 0) `CHK(n, en)
        cyc(1);
    endtask

    task automatic t_basic();
        rd_chk(8'h02);
        wr(8'hff);
        rd_chk(8'hae);
        `CHK(si_clk_fast, 1'b1)
        wr(8'h00);
        rd_chk(8'h06);
        `CHK(dcs_host_pod_inst.last_rd[BIT_RSV], 1'b0)
        soft_clear();
        rd_chk(8'h02);
    endtask

    task automatic t_secure();
        secured <= 1'b1;
        cyc(1);
        wr(8'h8c);
        rd_chk(8'h00);
        secured <= 1'b0;
        cyc(1);
        rd_chk(8'h02);
    endtask

    task automatic t_stop();
        wr(8'h80);
        ack_enable <= 1'b1;
        stop_mode  <= 1'b1;
        cyc(3);
        `CHK(ack_long, 1'b1)
        `CHK({keep_dbg_clk, keep_all_clk}, 2'b10)
        wr(8'ha0);
        rd_chk(8'h82);
        pulse(0);
        `CHK(ack_long, 1'b0)
        stop_mode <= 1'b0;
        cyc(1);
        wr(8'ha0);
        stop_mode <= 1'b1;
        cyc(3);
        `CHK(keep_all_clk, 1'b1)
        wr(8'h00);
        dcs_host_pod_inst.send(CMD_READ_CSR, 8'h00);
        `CHK(dcs_host_pod_inst.last_ok, 1'b0)
        `CHK(dcs_host_pod_inst.last_rf, 1'b1)
        `CHK({keep_dbg_clk, keep_all_clk}, 2'b00)
        stop_mode  <= 1'b0;
        ack_enable <= 1'b0;
        cyc(1);
        rd_chk(8'h22);
        soft_clear();
    endtask

    task automatic t_debug();
        pulse(1);
        `CHK(debug_active, 1'b0)
        dcs_host_pod_inst.send(CMD_ENTER_DBG, 8'h00);
        `CHK(dcs_host_pod_inst.last_ok, 1'b0)
        `CHK(dcs_host_pod_inst.last_rf, 1'b1)
        wr(8'h80);
        pulse(1);
        `CHK(debug_active, 1'b1)
        rd_chk(8'hc2);
        dcs_host_pod_inst.send(CMD_EXIT_DBG, 8'h00);
        `CHK(debug_active, 1'b0)
        dcs_host_pod_inst.send(CMD_ENTER_DBG, 8'h00);
        `CHK(debug_active, 1'b1)
        soft_clear();
    endtask

    task automatic t_erase();
        dcs_host_pod_inst.send(CMD_ERASE, 8'h00);
        `CHK(erase_start, 1'b1)
        cyc(1);
        `CHK(erase_start, 1'b0)
        wr(8'h00);
        rd_chk(8'h03);
        pulse(2);
        rd_chk(8'h02);
        dcs_host_pod_inst.send(CMD_ERASE, 8'h00);
        soft_clear();
        rd_chk(8'h02);
    endtask

    task automatic t_mem();
        wr(8'h80);
        ack_enable <= 1'b1;
        mem_chk(1'b0, TO + 1);
        bus_free <= 1'b1;
        mem_chk(1'b1, 0);
        bus_free <= 1'b0;
        wr(8'h88);
        mem_chk(1'b1, 1);
        ack_enable <= 1'b0;
        wr(8'h80);
        mem_chk(1'b1, 1);
    endtask

    task automatic t_special();
        hreset(1'b1);
        `CHK({debug_enable, debug_active}, 2'b11)
        rd_chk(8'hc2);
    endtask

    initial begin
        err_total     = 0;
        comparisons   = 0;
        rst_n         = 1'b0;
        soft_rst      = 1'b0;
        special_mode  = 1'b0;
        secured       = 1'b0;
        stop_mode     = 1'b0;
        dbg_entry_req = 1'b0;
        erase_done    = 1'b0;
        ack_enable    = 1'b0;
        ack_issued    = 1'b0;
        bus_free      = 1'b0;
        @(posedge clk);
        hreset(1'b0);
        t_basic();
        t_secure();
        t_stop();
        t_debug();
        t_erase();
        t_mem();
        t_special();
        finish_test();
    end

    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        finish_test();
    end
endmodule
